/* File: bench/output_stage_model.sv */
// Behavioural model of the transistor and relay output stages
`timescale 1ns/1ns
`default_nettype none
module output_stage_model
   import dout_pkg::*;
(
   input wire logic [NUM_LINES-1:0] output_line, // Drive levels from the selector
   output logic [NUM_LINES-1:0] energised // Load current flowing
);
   // High saturates the transistor or pulls in the coil, low leaves the load open
   assign energised = output_line;
endmodule // output_stage_model
`default_nettype wire

/* File: bench/testbench.sv */
// Self-checking bench for the digital output selector
`timescale 1ns/1ns
`default_nettype none
module testbench;
   import dout_pkg::*;
   typedef struct {string name; logic [31:0] exp; int src;} note_type;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [3:0] pstrb = 4'hF;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   drive_status_type status = '0;
   measure_type meas = '0;
   logic [1:0] timer_control_input = 2'b00;
   logic [NUM_LINES-1:0] output_line;
   logic [NUM_LINES-1:0] energised;
   logic [31:0] rd_seen = 32'h0;
   logic err_seen = 1'b0;
   note_type notes[$];
   note_type cur_note;
   event obs_ev;
   integer miscompares = 0;
   integer checks_done = 0;
   integer seed = 32'h653F5D23;
   logic [7:0] ofs[8] = '{FUNC_SEL_OFS, SPEED_PT_OFS, SPEED_CFG_OFS, LOAD_PT_OFS,
      FREQ_PT_OFS, CTRL_OFS, RELAY2_DLY_OFS, RELAY3_DLY_OFS};
   logic [31:0] rst[8] = '{FUNC_SEL_RST, SPEED_PT_RST, SPEED_CFG_RST, LOAD_PT_RST,
      FREQ_PT_RST, CTRL_RST, DELAY_RST, DELAY_RST};
   logic [5:0] codes[23] = '{6'h0A, 6'h0B, 6'h0C, 6'h0D, 6'h0E, 6'h0F, 6'h10, 6'h11, 6'h12,
      6'h13, 6'h15, 6'h18, 6'h19, 6'h1A, 6'h21, 6'h22, 6'h23, 6'h24, 6'h26, 6'h27, 6'h28,
      6'h29, 6'h2A};

   always #4 pclk = ~pclk;

   drive_digital_output_selector #(.TICK_CYCLES(4)) DUT (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .status(status), .meas(meas),
      .timer_control_input(timer_control_input), .output_line(output_line)
   );
   output_stage_model stage (.output_line(output_line), .energised(energised));

   // ------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------
   function automatic logic want(input logic [5:0] c, input drive_status_type s);
      case (c)
         6'h0A: return s.remote;
         6'h0B: return s.run;
         6'h0C: return !s.fault_any && !s.undervoltage;
         6'h0D: return !s.fault_any;
         6'h0E: return !s.overcurrent_fault;
         6'h0F: return !s.output_overcurrent_fault;
         6'h10: return !(s.line_unbalance_fault | s.link_undervoltage_fault
            | s.link_overvoltage_fault);
         6'h11: return !(s.phase_u_overtemp_fault | s.phase_v_overtemp_fault
            | s.phase_w_overtemp_fault);
         6'h12: return !s.motor_overload_fault;
         6'h13: return s.loop_ok;
         6'h15: return s.forward;
         6'h18: return s.ride_through;
         6'h19: return s.precharge_ok;
         6'h1A: return s.fault_any;
         6'h21: return s.safe_torque_stop_state;
         6'h22: return !s.safety_relay_fault;
         6'h23: return !s.alarm_any;
         6'h24: return !s.fault_any && !s.alarm_any;
         6'h26: return !s.sensor_overtemp_fault;
         6'h27: return !s.sensor_overtemp_alarm;
         6'h28: return !s.broken_cable_alarm;
         6'h29: return !s.sensor_overtemp_alarm && !s.broken_cable_alarm;
         default: return !s.sensor_overtemp_fault && !s.broken_cable_alarm;
      endcase
   endfunction

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic stop_test();
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   task automatic expect_val(input string name, input logic [31:0] exp, input int src);
      notes.push_back('{name, exp, src});
      -> obs_ev;
   endtask

   // Entered just after a rising edge; request held until pready is sampled high
   task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] data);
      int n;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= addr;
      pwdata <= data;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (pready !== 1'b1 && n < 16);
      rd_seen = prdata;
      err_seen = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1)
      begin
         miscompares++;
         stop_test();
      end
      @(posedge pclk);
   endtask

   task automatic rd(input string name, input logic [7:0] a, input logic [31:0] e,
      input logic err);
      apb(1'b0, a, 32'h0);
      expect_val(name, e, 1);
      expect_val("pslverr", {31'h0, err}, 2);
   endtask

   task automatic lines(input string name, input logic [4:0] exp, input int waitn);
      repeat (waitn) @(posedge pclk);
      expect_val(name, {27'h0, exp}, 0);
   endtask

   task automatic look(input string name, input logic [5:0] code, input logic exp);
      apb(1'b1, FUNC_SEL_OFS, {26'h0, code});
      lines(name, {4'h0, exp}, 3);
   endtask

   // Sampled a little after the edge so the registered outputs have landed
   always @(obs_ev)
   begin
      #1;
      while (notes.size() > 0)
      begin
         cur_note = notes.pop_front();
         if (cur_note.src == 0)
            check(cur_note.name, {27'h0, energised}, cur_note.exp);
         else if (cur_note.src == 1)
            check(cur_note.name, rd_seen, cur_note.exp);
         else
            check(cur_note.name, {31'h0, err_seen}, cur_note.exp);
      end
   end

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial
   begin
      status <= '1;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      lines("unused lines", 5'h00, 2);
      for (int i = 0; i < 8; i++)
         rd("reset value", ofs[i], rst[i], 1'b0);
      rd("unmapped", 8'h24, 32'h0, 1'b1);
      pstrb <= 4'h1;
      apb(1'b1, FUNC_SEL_OFS, 32'hFFFF_FFFF);
      pstrb <= 4'hF;
      rd("byte lane", FUNC_SEL_OFS, 32'h0000_00FF, 1'b0);
      $display("registers done");
      for (int k = 0; k < 6; k++)
      begin
         status <= 23'($random(seed));
         @(posedge pclk);
         foreach (codes[j])
            look("status code", codes[j], want(codes[j], status));
      end
      status <= '1;
      look("unused", F_UNUSED, 1'b0);
      look("timer on line 1", F_TIMER, 1'b0);
      $display("status functions done");
      meas.motor_current_reading <= 16'h0064;
      look("current above", 6'h06, 1'b0);
      look("current below", 6'h07, 1'b0);
      meas.motor_current_reading <= 16'h0065;
      look("current above", 6'h06, 1'b1);
      meas.motor_speed_reading <= 16'h0011;
      look("zero speed", 6'h05, 1'b1);
      meas.motor_speed_reading <= 16'h0012;
      look("zero speed", 6'h05, 1'b0);
      meas.torque_reading <= 16'h0065;
      look("torque scalar", 6'h08, 1'b0);
      apb(1'b1, CTRL_OFS, 32'h0000_0300);
      look("torque vector", 6'h08, 1'b1);
      look("torque below", 6'h09, 1'b0);
      meas.motor_speed_reading <= 16'h0079;
      meas.total_reference <= 16'h0079;
      look("speed and ref", 6'h1E, 1'b0);
      apb(1'b1, CTRL_OFS, 32'h0000_0400);
      look("speed and ref", 6'h1E, 1'b1);
      meas.total_reference <= 16'h0078;
      look("speed and ref", 6'h1E, 1'b0);
      look("speed above", 6'h02, 1'b1);
      meas.motor_speed_reading <= 16'h006E;
      look("speed above", 6'h02, 1'b1);
      meas.motor_speed_reading <= 16'h0065;
      look("speed above", 6'h02, 1'b0);
      meas.motor_speed_reading <= 16'h0710;
      look("speed below", 6'h03, 1'b1);
      meas.motor_speed_reading <= 16'h071B;
      look("speed below", 6'h03, 1'b0);
      meas.speed_reference_reading <= 16'h0079;
      look("reference above", 6'h01, 1'b1);
      meas.motor_frequency_reading <= 12'h029;
      look("freq above", 6'h1F, 1'b1);
      meas.motor_frequency_reading <= 12'h019;
      look("freq above", 6'h20, 1'b1);
      meas.motor_frequency_reading <= 12'h013;
      look("freq above", 6'h1F, 1'b0);
      $display("measurement functions done");
      apb(1'b1, CTRL_OFS, 32'h0000_0015);
      apb(1'b1, FUNC_SEL_OFS, {2'h0, {5{6'h14}}});
      lines("network", 5'h15, 3);
      apb(1'b1, CTRL_OFS, 32'h0000_000A);
      lines("network", 5'h0A, 3);
      // Relay 2 waits 12 cycles to close, relay 3 has no delay
      apb(1'b1, RELAY2_DLY_OFS, 32'h0001_0003);
      // Line 5 also asks for the timer, which it does not have, so it must stay off
      apb(1'b1, FUNC_SEL_OFS, {2'h0, F_TIMER, F_UNUSED, {3{F_TIMER}}});
      timer_control_input <= 2'b11;
      lines("timer early", 5'h04, 8);
      timer_control_input <= 2'b10;
      lines("timer dip", 5'h04, 4);
      timer_control_input <= 2'b11;
      lines("timer restart", 5'h04, 10);
      lines("timer on", 5'h06, 14);
      rd("status word", STATUS_OFS, 32'h0000_0066, 1'b0);
      timer_control_input <= 2'b00;
      lines("timer off", 5'h00, 20);
      $display("network and timer done");
      stop_test();
   end

   initial
   begin
      #800000;
      miscompares++;
      stop_test();
   end
endmodule // testbench
`default_nettype wire

/* File: rtl/dout_pkg.sv */
// Package: register map, field layout, function codes and carriers for the output selector
//--------------------------------------------------------------------------
// How it works
// RULE1 - Each output line is active exactly while its selected condition is true.
// RULE2 - Active means stage energised; current function compares strictly above threshold.
// RULE3 - Function code unused keeps the line permanently de-energised.
// RULE4 - Zero speed is active while motor speed is below the zero speed zone.
// RULE5 - Torque above/below work only when control type is 3 or 4.
// RULE6 - Run is active whenever the power stage is enabled, at any speed.
// RULE7 - Ready is active only with no fault and no undervoltage.
// RULE8 - Each grouped fault-absence function is active when no fault of its group.
// RULE9 - Current loop OK is active while the analog loop is inside range.
// RULE10 - Network mode follows the value written by the remote master.
// RULE11 - Forward is active while turning forward, inactive in reverse.
// RULE12 - Pre-charge OK is active while the DC link exceeds pre-charge level.
// RULE13 - Fault is active on any fault; no-fault is its complement.
// RULE14 - Timer function exists only on relay outputs 2 and 3.
// RULE15 - Combined speed needs control type 4, speed and total reference above threshold.
// RULE16 - No alarm, and no fault with no alarm, functions.
// RULE17 - Expansion sensor functions need no overtemperature fault/alarm and no broken cable.
// RULE18 - Relay timer input must hold its new level for the on/off delay.
// RULE19 - Frequency functions compare output frequency with an adjustable threshold.
// RULE20 - Ride-through is active while ride-through is executing.
// RULE21 - Remote is active while the command source is remote.
// RULE22 - Speed above/below thresholds use a configurable hysteresis band.
// RULE23 - Frequency above clears only below threshold minus hysteresis.
// RULE24 - Conditions are evaluated every clock and outputs are registered.
//--------------------------------------------------------------------------
package dout_pkg;
   localparam int NUM_LINES = 5;
   localparam int FUNC_W = 6;
   // Register byte offsets
   localparam logic [7:0] FUNC_SEL_OFS = 8'h00;
   localparam logic [7:0] SPEED_PT_OFS = 8'h04;
   localparam logic [7:0] SPEED_CFG_OFS = 8'h08;
   localparam logic [7:0] LOAD_PT_OFS = 8'h0C;
   localparam logic [7:0] FREQ_PT_OFS = 8'h10;
   localparam logic [7:0] CTRL_OFS = 8'h14;
   localparam logic [7:0] RELAY2_DLY_OFS = 8'h18;
   localparam logic [7:0] RELAY3_DLY_OFS = 8'h1C;
   localparam logic [7:0] STATUS_OFS = 8'h20;
   // Field positions
   localparam int HI_FIELD_LSB = 16;
   localparam int CTRL_TYPE_LSB = 8;
   // Reset values
   localparam logic [31:0] FUNC_SEL_RST = 32'h0000_0000;
   localparam logic [31:0] SPEED_PT_RST = 32'h0708_0078;
   localparam logic [31:0] SPEED_CFG_RST = 32'h0012_0012;
   localparam logic [31:0] LOAD_PT_RST = 32'h0064_0064;
   localparam logic [31:0] FREQ_PT_RST = 32'h0014_0028;
   localparam logic [31:0] CTRL_RST = 32'h0000_0000;
   localparam logic [31:0] DELAY_RST = 32'h0000_0000;
   // Timing: delays count in tenths of a second
   localparam int CLK_PERIOD_NS = 8;
   localparam int DELAY_UNIT_NS = 100_000_000;
   localparam int DELAY_UNIT_CYCLES = DELAY_UNIT_NS / CLK_PERIOD_NS;
   // Function codes and control type values
   localparam logic [FUNC_W-1:0] F_UNUSED = 6'h00;
   localparam logic [FUNC_W-1:0] F_TIMER = 6'h1D;
   localparam logic [2:0] CT_VECTOR_SENSORLESS = 3'h3;
   localparam logic [2:0] CT_VECTOR_ENCODER = 3'h4;

   typedef struct packed {
      logic run;
      logic undervoltage;
      logic remote;
      logic forward;
      logic ride_through;
      logic precharge_ok;
      logic loop_ok;
      logic fault_any;
      logic alarm_any;
      logic overcurrent_fault;
      logic output_overcurrent_fault;
      logic line_unbalance_fault;
      logic link_undervoltage_fault;
      logic link_overvoltage_fault;
      logic phase_u_overtemp_fault;
      logic phase_v_overtemp_fault;
      logic phase_w_overtemp_fault;
      logic motor_overload_fault;
      logic safety_relay_fault;
      logic safe_torque_stop_state;
      logic sensor_overtemp_fault;
      logic sensor_overtemp_alarm;
      logic broken_cable_alarm;
   } drive_status_type;

   typedef struct packed {
      logic [15:0] motor_speed_reading;
      logic [15:0] speed_reference_reading;
      logic [15:0] total_reference;
      logic [15:0] motor_current_reading;
      logic [15:0] torque_reading;
      logic [11:0] motor_frequency_reading;
   } measure_type;
endpackage

/* File: rtl/drive_digital_output_selector.sv */
// Selectable condition logic driving the five transistor/relay output lines
`timescale 1ns/1ns
`default_nettype none
module drive_digital_output_selector
   import dout_pkg::*;
#(
   parameter int unsigned TICK_CYCLES = DELAY_UNIT_CYCLES
)
(
   input wire logic pclk, // APB clock, 125 MHz
   input wire logic presetn, // Async reset, active low
   input wire logic psel, // APB select
   input wire logic penable, // APB access phase
   input wire logic pwrite, // APB direction
   input wire logic [7:0] paddr, // APB byte address
   input wire logic [31:0] pwdata, // APB write data
   input wire logic [3:0] pstrb, // APB byte strobes
   output logic [31:0] prdata, // APB read data
   output logic pready, // APB ready
   output logic pslverr, // APB error, unmapped address
   input wire drive_status_type status, // Drive states, same clock
   input wire measure_type meas, // Measurements, same clock
   input wire logic [1:0] timer_control_input, // Pins steering relay 2/3 timers
   output logic [NUM_LINES-1:0] output_line // High energises the stage
);

   //------------------------------------------------------------------------
   // Register bus
   //------------------------------------------------------------------------
   logic [31:0] func_q, speed_pt_q, speed_cfg_q, load_pt_q, freq_pt_q, ctrl_q;
   logic [31:0] rly2_q, rly3_q;
   logic [NUM_LINES-1:0] line_q, line_d;
   logic [1:0] relay_q;

   wire [31:0] wmask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
   wire wr_en = psel & penable & pwrite;
   wire sel_func = paddr == FUNC_SEL_OFS;
   wire sel_spt = paddr == SPEED_PT_OFS;
   wire sel_scfg = paddr == SPEED_CFG_OFS;
   wire sel_load = paddr == LOAD_PT_OFS;
   wire sel_freq = paddr == FREQ_PT_OFS;
   wire sel_ctrl = paddr == CTRL_OFS;
   wire sel_r2 = paddr == RELAY2_DLY_OFS;
   wire sel_r3 = paddr == RELAY3_DLY_OFS;
   wire sel_stat = paddr == STATUS_OFS;
   wire mapped = sel_func | sel_spt | sel_scfg | sel_load | sel_freq | sel_ctrl | sel_r2 |
      sel_r3 | sel_stat;
   wire [31:0] status_word = {25'h0, relay_q, line_q};

   // Zero wait state slave; the error flag only matters in the access phase
   assign pready = 1'b1;
   assign pslverr = psel & penable & ~mapped;

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
      input logic [31:0] m);
      merge = (old & ~m) | (nw & m);
   endfunction

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         func_q <= FUNC_SEL_RST;
         speed_pt_q <= SPEED_PT_RST;
         speed_cfg_q <= SPEED_CFG_RST;
         load_pt_q <= LOAD_PT_RST;
         freq_pt_q <= FREQ_PT_RST;
         ctrl_q <= CTRL_RST;
         rly2_q <= DELAY_RST;
         rly3_q <= DELAY_RST;
      end
      else if (wr_en)
      begin
         if (sel_func) func_q <= merge(func_q, pwdata, wmask);
         if (sel_spt) speed_pt_q <= merge(speed_pt_q, pwdata, wmask);
         if (sel_scfg) speed_cfg_q <= merge(speed_cfg_q, pwdata, wmask);
         if (sel_load) load_pt_q <= merge(load_pt_q, pwdata, wmask);
         if (sel_freq) freq_pt_q <= merge(freq_pt_q, pwdata, wmask);
         if (sel_ctrl) ctrl_q <= merge(ctrl_q, pwdata, wmask);
         if (sel_r2) rly2_q <= merge(rly2_q, pwdata, wmask);
         if (sel_r3) rly3_q <= merge(rly3_q, pwdata, wmask);
      end
   end

   // Read data registered during setup so it is stable in the access phase
   wire [31:0] rd_d = sel_func ? func_q : sel_spt ? speed_pt_q : sel_scfg ? speed_cfg_q :
      sel_load ? load_pt_q : sel_freq ? freq_pt_q : sel_ctrl ? ctrl_q : sel_r2 ? rly2_q :
      sel_r3 ? rly3_q : sel_stat ? status_word : 32'h0000_0000;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prdata <= 32'h0000_0000;
      else if (psel & ~penable)
         prdata <= rd_d;
   end

   //------------------------------------------------------------------------
   // Configuration fields
   //------------------------------------------------------------------------
   wire [15:0] speed_threshold_x = speed_pt_q[15:0];
   wire [15:0] speed_threshold_y = speed_pt_q[31:HI_FIELD_LSB];
   wire [15:0] zero_speed_zone = speed_cfg_q[15:0];
   wire [9:0] speed_hysteresis = speed_cfg_q[HI_FIELD_LSB+9:HI_FIELD_LSB];
   wire [15:0] current_threshold = load_pt_q[15:0];
   wire [15:0] torque_threshold = load_pt_q[31:HI_FIELD_LSB];
   wire [11:0] frequency_threshold = freq_pt_q[11:0];
   wire [11:0] frequency_hysteresis = freq_pt_q[HI_FIELD_LSB+11:HI_FIELD_LSB];
   wire [NUM_LINES-1:0] network_output_value = ctrl_q[NUM_LINES-1:0];
   wire [2:0] control_type_select = ctrl_q[CTRL_TYPE_LSB+2:CTRL_TYPE_LSB];
   wire vector_mode = (control_type_select == CT_VECTOR_SENSORLESS) |
      (control_type_select == CT_VECTOR_ENCODER);
   wire encoder_mode = control_type_select == CT_VECTOR_ENCODER;
   wire [15:0] spd = meas.motor_speed_reading;
   wire [11:0] frq = meas.motor_frequency_reading;

   //------------------------------------------------------------------------
   // Hysteresis comparators
   //------------------------------------------------------------------------
   logic above_x_q, below_y_q, freq_above_q;
   // Sums are one bit wider so a large band cannot wrap
   wire [16:0] spd_plus_h = {1'b0, spd} + {7'h00, speed_hysteresis};
   wire [16:0] ny_plus_h = {1'b0, speed_threshold_y} + {7'h00, speed_hysteresis};
   wire [12:0] frq_plus_h = {1'b0, frq} + {1'b0, frequency_hysteresis};
   wire above_x_d = (spd > speed_threshold_x) ? 1'b1 : // [RULE22]
      (spd_plus_h < {1'b0, speed_threshold_x}) ? 1'b0 : above_x_q;
   wire below_y_d = (spd < speed_threshold_y) ? 1'b1 : // [RULE22]
      ({1'b0, spd} > ny_plus_h) ? 1'b0 : below_y_q;
   wire freq_above_d = (frq > frequency_threshold) ? 1'b1 : // [RULE19]
      (frq_plus_h < {1'b0, frequency_threshold}) ? 1'b0 : freq_above_q; // [RULE23]

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         above_x_q <= 1'b0;
         below_y_q <= 1'b0;
         freq_above_q <= 1'b0;
      end
      else
      begin
         above_x_q <= above_x_d;
         below_y_q <= below_y_d;
         freq_above_q <= freq_above_d;
      end
   end

   //------------------------------------------------------------------------
   // Condition vector indexed by function code
   //------------------------------------------------------------------------
   logic [63:0] cond;
   wire no_fault = ~status.fault_any;

   always_comb
   begin
      cond = 64'h0;
      cond[1] = meas.speed_reference_reading > speed_threshold_x;
      cond[2] = above_x_q; // [RULE22]
      cond[3] = below_y_q; // [RULE22]
      cond[5] = spd < zero_speed_zone; // [RULE4]
      cond[6] = meas.motor_current_reading > current_threshold; // [RULE2]
      cond[7] = meas.motor_current_reading < current_threshold;
      cond[8] = vector_mode & (meas.torque_reading > torque_threshold); // [RULE5]
      cond[9] = vector_mode & (meas.torque_reading < torque_threshold); // [RULE5]
      cond[10] = status.remote; // [RULE21]
      cond[11] = status.run; // [RULE6]
      cond[12] = no_fault & ~status.undervoltage; // [RULE7]
      cond[13] = no_fault; // [RULE13]
      cond[14] = ~status.overcurrent_fault; // [RULE8]
      cond[15] = ~status.output_overcurrent_fault; // [RULE8]
      cond[16] = ~(status.line_unbalance_fault | status.link_undervoltage_fault |
         status.link_overvoltage_fault); // [RULE8]
      cond[17] = ~(status.phase_u_overtemp_fault | status.phase_v_overtemp_fault |
         status.phase_w_overtemp_fault); // [RULE8]
      cond[18] = ~status.motor_overload_fault; // [RULE8]
      cond[19] = status.loop_ok; // [RULE9]
      cond[21] = status.forward; // [RULE11]
      cond[24] = status.ride_through; // [RULE20]
      cond[25] = status.precharge_ok; // [RULE12]
      cond[26] = status.fault_any; // [RULE13]
      cond[30] = encoder_mode & (spd > speed_threshold_x) &
         (meas.total_reference > speed_threshold_x); // [RULE15]
      cond[31] = freq_above_q; // [RULE19]
      cond[32] = freq_above_q; // [RULE19]
      cond[33] = status.safe_torque_stop_state;
      cond[34] = ~status.safety_relay_fault; // [RULE8]
      cond[35] = ~status.alarm_any; // [RULE16]
      cond[36] = no_fault & ~status.alarm_any; // [RULE16]
      cond[38] = ~status.sensor_overtemp_fault; // [RULE17]
      cond[39] = ~status.sensor_overtemp_alarm; // [RULE17]
      cond[40] = ~status.broken_cable_alarm; // [RULE17]
      cond[41] = ~status.sensor_overtemp_alarm & ~status.broken_cable_alarm; // [RULE17]
      cond[42] = ~status.sensor_overtemp_fault & ~status.broken_cable_alarm; // [RULE17]
   end

   //------------------------------------------------------------------------
   // Relay timers for lines 2 and 3
   //------------------------------------------------------------------------
   logic [1:0] di_meta_q, di_sync_q;
   logic [1:0][23:0] sub_q;
   logic [1:0][11:0] tenths_q;

   // Pins are asynchronous to pclk
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         di_meta_q <= 2'h0;
         di_sync_q <= 2'h0;
      end
      else
      begin
         di_meta_q <= timer_control_input;
         di_sync_q <= di_meta_q;
      end
   end

   genvar k;
   generate
      for (k = 0; k < 2; k++)
      begin : g_timer
         wire [31:0] dly_reg = (k == 0) ? rly2_q : rly3_q;
         wire [11:0] dly = relay_q[k] ? dly_reg[HI_FIELD_LSB+11:HI_FIELD_LSB] : dly_reg[11:0];
         wire pending = di_sync_q[k] != relay_q[k];
         wire done = tenths_q[k] >= dly;
         wire tick = sub_q[k] == 24'(TICK_CYCLES - 1);
         always_ff @(posedge pclk or negedge presetn)
         begin
            if (!presetn)
            begin
               relay_q[k] <= 1'b0;
               sub_q[k] <= 24'h0;
               tenths_q[k] <= 12'h0;
            end
            else if (!pending || done)
            begin
               // A reversal before the delay ends restarts the count
               if (pending) relay_q[k] <= di_sync_q[k]; // [RULE18]
               sub_q[k] <= 24'h0;
               tenths_q[k] <= 12'h0;
            end
            else if (tick)
            begin
               sub_q[k] <= 24'h0;
               tenths_q[k] <= tenths_q[k] + 12'h1;
            end
            else
               sub_q[k] <= sub_q[k] + 24'h1;
         end
      end
   endgenerate

   //------------------------------------------------------------------------
   // Output selection
   //------------------------------------------------------------------------
   genvar i;
   generate
      for (i = 0; i < NUM_LINES; i++)
      begin : g_line
         wire [FUNC_W-1:0] code = func_q[i*FUNC_W +: FUNC_W];
         wire timer_ok = (i == 1) | (i == 2); // [RULE14]
         wire tmr = timer_ok ? relay_q[(i == 2) ? 1 : 0] : 1'b0;
         assign line_d[i] = (code == F_UNUSED) ? 1'b0 : // [RULE3]
            (code == 6'h14) ? network_output_value[i] : // [RULE10]
            (code == F_TIMER) ? tmr : cond[code]; // [RULE1] [RULE14]
      end
   endgenerate

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         line_q <= '0;
      else
         line_q <= line_d; // [RULE24]
   end

   assign output_line = line_q;

   //------------------------------------------------------------------------
   // Assertions
   //------------------------------------------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   unused_off_a: assert property (func_q[5:0] == F_UNUSED |=> !output_line[0]) // [RULE3]
      else $error("unused line 0 energised");
   run_follow_a: assert property (func_q[5:0] == 6'h0B && $stable(func_q)
      |=> output_line[0] == $past(status.run)) // [RULE6]
      else $error("run line does not follow run state");
   torque_gate_a: assert property (func_q[5:0] == 6'h08 && !vector_mode && $stable(func_q)
      |=> !output_line[0]) // [RULE5]
      else $error("torque line active outside vector mode");
   ready_def_a: assert property (func_q[5:0] == 6'h0C && $stable(func_q)
      |=> output_line[0] == $past(!status.fault_any && !status.undervoltage)) // [RULE7]
      else $error("ready line wrong");
   net_value_a: assert property (func_q[11:6] == 6'h14 && $stable(func_q)
      |=> output_line[1] == $past(ctrl_q[1])) // [RULE10]
      else $error("network value not followed");
   timer_line_a: assert property (func_q[29:24] == F_TIMER |=> !output_line[4]) // [RULE14]
      else $error("timer on line without relay timer");
   timer_hold_a: assert property (!(di_sync_q[0] != relay_q[0]) // [RULE18]
      |=> $stable(relay_q[0]))
      else $error("relay timer changed without input change");
   freq_hyst_a: assert property (freq_above_q && frq_plus_h >= {1'b0, frequency_threshold}
      |=> freq_above_q) // [RULE23]
      else $error("frequency flag dropped inside hysteresis");
   speed_hyst_a: assert property (spd > speed_threshold_x |=> above_x_q) // [RULE22]
      else $error("speed above flag not set");
   zero_speed_a: assert property (func_q[5:0] == 6'h05 && $stable(func_q)
      |=> output_line[0] == $past(spd < zero_speed_zone)) // [RULE4]
      else $error("zero speed line wrong");

endmodule // drive_digital_output_selector
`default_nettype wire
